/* File: bench/spi_master_slave_port_checker.sv */
module spi_port_checker (
  // clock and reset
  input wire clock,
  input wire sys_rst,
  // register port
  input wire [7:0] addr,
  input wire [7:0] wr_data,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] rd_data,
  // interrupt and pins
  input wire serial_irq_gate,
  input wire uart_irq_req,
  input wire irq_request,
  input wire wake_idle,
  input wire sck_oe,
  input wire mosi_oe,
  input wire miso_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);
  sequence ctl_wr;
    wr_stb && addr == 8'hd5;
  endsequence
  sequence ctl_rd;
    rd_stb && addr == 8'hd5;
  endsequence
  sequence off_wr;
    ctl_wr ##0 !wr_data[6];
  endsequence
  gate_off_a: assert property ($past(!serial_irq_gate) |-> !irq_request)
    else $error("irq without gate");
  uart_share_a: assert property (!$past(sys_rst) && $past(serial_irq_gate && uart_irq_req) |-> irq_request)
    else $error("uart request lost");
  master_pins_a: assert property (sck_oe |-> mosi_oe && !miso_oe)
    else $error("master pin enables");
  slave_pins_a: assert property (miso_oe |-> !sck_oe && !mosi_oe)
    else $error("slave pin enables");
  wake_slave_a: assert property (wake_idle |-> !sck_oe ##1 !wake_idle)
    else $error("bad wake pulse");
  port_off_a: assert property (off_wr |-> ##2 !(sck_oe || mosi_oe || miso_oe))
    else $error("pins kept after disable");
  ctrl_echo_a: assert property (ctl_wr ##2 ctl_rd |=> rd_data == $past(wr_data, 3))
    else $error("control readback");
  stat_low_a: assert property (rd_stb && addr == 8'haa |=> rd_data[5:0] == 6'h00)
    else $error("status low bits");
endmodule // spi_port_checker

bind spi_master_slave_port spi_port_checker u_spi_port_checker (.*);

/* File: bench/spi_master_slave_port_tb.sv */
module spi_master_slave_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MB = 8;
  logic clock = 1'b0, sys_rst = 1'b1, wr_stb = 1'b0, rd_stb = 1'b0, ss_n_in = 1'b1, load = 1'b0;
  logic serial_irq_gate = 1'b0, uart_irq_req = 1'b0;
  logic ext_sck = 1'b0, ext_mosi = 1'b0;
  logic [7:0] addr = 8'h00, wr_data = 8'h00, pt = 8'h00, sm = 8'h00, v, tx;
  wire [7:0] rd_data, prx;
  wire irq_request, wake_idle, sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, pmiso;
  // released pins: the bench plays the external master on sck and mosi, the partner drives miso; clock idle low
  wire sck_in = sck_oe ? sck_out : ext_sck;
  wire mosi_in = mosi_oe ? mosi_out : ext_mosi;
  wire miso_in = miso_oe ? miso_out : pmiso;
  int bad_count = 0, checks_done = 0, wakes = 0, n, dv[4] = '{4, 16, 64, 128};
  realtime tr = 0, per = 0;
  always #2.5 clock = ~clock;
  always @(posedge clock) if (wake_idle) wakes <= wakes + 1;
  always @(posedge sck_in) begin
    per = $realtime - tr;
    tr = $realtime;
  end
  spi_master_slave_port #(.MIN_BIT_CYCLES(MB)) u_spi_master_slave_port (.*);
  spi_partner u_spi_partner (.sck(sck_in), .mosi(mosi_in), .miso(pmiso), .load, .tx_byte(pt), .rx_byte(prx));
  task chk(input logic [7:0] g, e);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge clock);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1 d = rd_data;
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int k = 0; k < 8; k++) rev[k] = b[7 - k];
  endfunction
  initial begin
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    rd(8'hd5, v);
    chk(v, 8'h04);
    rd(8'haa, v);
    chk(v, 8'h00);
    rd(8'h10, v);
    chk(v, 8'h00);
    wr(8'hd5, 8'h2b);
    rd(8'hd5, v);
    chk(v, 8'h2b);
    $display("registers done");
    @(posedge clock);
    serial_irq_gate <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      wr(8'hd5, {i == 3, 1'b1, i[0], 5'h10 | 5'(i)});
      pt <= 8'h5a ^ 8'(i);
      load <= 1'b1;
      @(posedge clock);
      load <= 1'b0;
      tx = 8'hc3 + 8'(i);
      wr(8'h86, tx);
      if (i == 0) wr(8'h86, 8'hff);
      for (n = 0; n < 1000 && v[7] !== 1'b1; n++) rd(8'haa, v);
      if (n == 1000) begin
        bad_count++;
        give_verdict;
      end
      chk(v, i == 0 ? 8'hc0 : 8'h80);
      chk({7'h00, irq_request}, {7'h00, i == 3});
      chk(8'($rtoi(per / 10.0)), 8'(dv[i] < MB ? MB / 2 : dv[i] / 2));
      rd(8'h86, v);
      chk(v, i[0] ? rev(pt) : pt);
      chk(prx, i[0] ? rev(tx) : tx);
      rd(8'haa, v);
      chk(v, 8'h00);
    end
    chk({7'h00, irq_request}, 8'h00);
    @(posedge clock);
    uart_irq_req <= 1'b1;
    repeat (2) @(posedge clock);
    #1 chk({7'h00, irq_request}, 8'h01);
    @(posedge clock);
    serial_irq_gate <= 1'b0;
    repeat (2) @(posedge clock);
    #1 chk({7'h00, irq_request}, 8'h00);
    $display("master done");
    wr(8'hd5, 8'h40);
    wr(8'h86, 8'h96);
    ss_n_in <= 1'b0;
    repeat (6) @(posedge clock);
    #1 chk({6'h00, miso_oe, sck_oe}, 8'h02);
    tx = 8'h3c;
    for (int b = 7; b >= 0; b--) begin
      @(posedge clock);
      ext_mosi <= tx[b];
      repeat (4) @(posedge clock);
      #1 sm = {sm[6:0], miso_out};
      @(posedge clock);
      ext_sck <= 1'b1;
      repeat (4) @(posedge clock);
      ext_sck <= 1'b0;
    end
    repeat (6) @(posedge clock);
    chk(8'(wakes), 8'h01);
    rd(8'haa, v);
    chk(v, 8'h80);
    rd(8'h86, v);
    chk(v, tx);
    chk(sm, 8'h96);
    chk(prx, tx);
    $display("slave done");
    @(posedge clock);
    ss_n_in <= 1'b1;
    repeat (6) @(posedge clock);
    #1 chk({6'h00, miso_oe, sck_oe}, 8'h00);
    wr(8'hd5, 8'h00);
    $display("pins done");
    give_verdict;
  end
endmodule // spi_master_slave_port_tb

/* File: bench/spi_partner.sv */
module spi_partner (
  // link pins
  input wire sck,
  input wire mosi,
  output wire miso,
  // bench side
  input wire load,
  input wire [7:0] tx_byte,
  output logic [7:0] rx_byte
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sr;
  // mode 0, msb first; the bench reverses bytes for lsb first
  always @(posedge sck) rx_byte <= {rx_byte[6:0], mosi};
  // refill toggles so a stale bit never reads as valid
  always @(posedge load or negedge sck) sr <= load ? tx_byte : {sr[6:0], ~sr[0]};
  assign miso = sr[7];
endmodule // spi_partner

/* File: rtl/spi_master_slave_port.v */
// Chosen here: the address-and-strobe port.
`include "spi_port_defs.vh"

module spi_master_slave_port #(
  parameter MIN_BIT_CYCLES = `MIN_BIT_CYCLES
) (
  // clock and reset
  input  wire       clock,
  input  wire       sys_rst,
  // register port
  input  wire [7:0] addr,
  input  wire [7:0] wr_data,
  input  wire       wr_stb,
  input  wire       rd_stb,
  output reg  [7:0] rd_data,
  // shared serial interrupt
  input  wire       serial_irq_gate,
  input  wire       uart_irq_req,
  output reg        irq_request,
  output reg        wake_idle,
  // link pins
  input  wire       ss_n_in,
  input  wire       sck_in,
  output reg        sck_out,
  output reg        sck_oe,
  input  wire       mosi_in,
  output wire       mosi_out,
  output reg        mosi_oe,
  input  wire       miso_in,
  output wire       miso_out,
  output reg        miso_oe
);

  // half periods in system clocks; integer math first, then cut to the counter width
  localparam integer MIN_HALF_I = (MIN_BIT_CYCLES + 1) / 2;
  localparam integer HALF0_I    = `DIV_CODE0 / 2;
  localparam integer HALF1_I    = `DIV_CODE1 / 2;
  localparam integer HALF2_I    = `DIV_CODE2 / 2;
  localparam integer HALF3_I    = `DIV_CODE3 / 2;
  localparam [7:0]   MIN_HALF   = MIN_HALF_I[7:0];
  localparam [7:0]   HALF0      = HALF0_I[7:0];
  localparam [7:0]   HALF1      = HALF1_I[7:0];
  localparam [7:0]   HALF2      = HALF2_I[7:0];
  localparam [7:0]   HALF3      = HALF3_I[7:0];

  function [7:0] shift_in;
    input [7:0] cur;
    input       bit_in;
    input       lsb_first;
    begin
      shift_in = lsb_first ? {bit_in, cur[7:1]} : {cur[6:0], bit_in};
    end
  endfunction

  function out_bit;
    input [7:0] cur;
    input       lsb_first;
    begin
      out_bit = lsb_first ? cur[0] : cur[7];
    end
  endfunction

  // one compare per strobe and register
  function reg_hit;
    input       stb;
    input [7:0] cur_addr;
    input [7:0] reg_addr;
    begin
      reg_hit = stb && (cur_addr == reg_addr);
    end
  endfunction

  // control and flags
  reg  [7:0] ctrl;
  reg        xfer_done_flag;
  reg        write_clash_flag;
  reg        clear_armed;

  // shift path
  reg  [7:0] shift_data_reg;
  reg  [7:0] rx_buf;
  reg        data_out;
  reg        in_bit;
  reg  [2:0] bit_cnt;
  reg        busy;
  reg        lead_seen;
  reg  [7:0] half_cnt;

  // synchroniser stages
  reg        ss_s1;
  reg        ss_s2;
  reg        sck_s1;
  reg        sck_s2;
  reg        sck_s3;
  reg        mosi_s1;
  reg        mosi_s2;
  reg        miso_s1;
  reg        miso_s2;

  // combinational helpers
  reg  [7:0] half_len;
  reg  [7:0] next_shift;

  // control fields
  wire xfer_irq_enable  = ctrl[`CTRL_IRQ_EN];
  wire port_on          = ctrl[`CTRL_PORT_ON];
  wire bit_order_sel    = ctrl[`CTRL_ORDER];
  wire controller_sel   = ctrl[`CTRL_MASTER];
  wire clock_idle_level = ctrl[`CTRL_IDLE_LEVEL];
  wire clock_sample_phase = ctrl[`CTRL_PHASE];
  wire rate_sel_hi      = ctrl[`CTRL_RATE_HI];
  wire rate_sel_lo      = ctrl[`CTRL_RATE_LO];

  // register strobes
  wire data_wr   = reg_hit(wr_stb, addr, `SPI_ADDR_DATA);
  wire data_rd   = reg_hit(rd_stb, addr, `SPI_ADDR_DATA);
  wire status_rd = reg_hit(rd_stb, addr, `SPI_ADDR_STATUS);
  wire ctrl_wr   = reg_hit(wr_stb, addr, `SPI_ADDR_CONTROL);

  wire master_on = port_on && controller_sel;
  wire slave_on  = port_on && !controller_sel && !ss_s2;

  // half period: documented divisor, but never faster than the link limit
  always @* begin
    case ({rate_sel_hi, rate_sel_lo})
      2'b00:   half_len = HALF0;
      2'b01:   half_len = HALF1;
      2'b10:   half_len = HALF2;
      2'b11:   half_len = HALF3;
      default: half_len = HALF0;
    endcase
    if (half_len < MIN_HALF) begin
      half_len = MIN_HALF;
    end
  end

  // edge events; slave edges arrive two to three clocks late
  wire gen_tick = master_on && busy && (half_cnt == half_len - 8'h01);
  wire m_lead   = gen_tick && (sck_out == clock_idle_level);
  wire m_trail  = gen_tick && (sck_out != clock_idle_level);
  wire s_edge   = slave_on && (sck_s2 != sck_s3);
  wire s_lead   = s_edge && (sck_s3 == clock_idle_level);
  wire s_trail  = s_edge && (sck_s3 != clock_idle_level);
  wire lead     = controller_sel ? m_lead : s_lead;
  wire trail    = controller_sel ? m_trail : s_trail;
  wire din      = controller_sel ? miso_s2 : mosi_s2;

  // phase 0 samples on leading edge, phase 1 on trailing edge
  wire sample_ev = clock_sample_phase ? trail : lead;
  wire shift_ev  = clock_sample_phase ? (lead && lead_seen) : trail;
  wire last      = (bit_cnt == 3'd7);
  wire finish    = clock_sample_phase ? (sample_ev && last) : (shift_ev && last);
  wire load      = data_wr && !busy;
  wire clash     = data_wr && busy;
  wire clear_now = clear_armed && (data_wr || data_rd);
  wire abort     = !port_on || (!controller_sel && ss_s2);
  // spi side of the shared serial source
  wire spi_irq_src = xfer_irq_enable && xfer_done_flag;

  always @* begin
    if (load) begin
      next_shift = wr_data;
    end else if (finish && clock_sample_phase) begin
      next_shift = shift_in(shift_data_reg, din, bit_order_sel);
    end else if (shift_ev) begin
      next_shift = shift_in(shift_data_reg, in_bit, bit_order_sel);
    end else begin
      next_shift = shift_data_reg;
    end
  end

  // pin synchronisers; select resets high so no false select follows reset
  always @(posedge clock) begin
    if (sys_rst) begin
      ss_s1 <= 1'b1;
      ss_s2 <= 1'b1;
    end else begin
      ss_s1 <= ss_n_in;
      ss_s2 <= ss_s1;
    end
  end

  // third sck stage only feeds the edge detector
  always @(posedge clock) begin
    if (sys_rst) begin
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
    end else begin
      sck_s1 <= sck_in;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      mosi_s1 <= 1'b0;
      mosi_s2 <= 1'b0;
      miso_s1 <= 1'b0;
      miso_s2 <= 1'b0;
    end else begin
      mosi_s1 <= mosi_in;
      mosi_s2 <= mosi_s1;
      miso_s1 <= miso_in;
      miso_s2 <= miso_s1;
    end
  end

  // data storage keeps its contents across reset
  always @(posedge clock) begin
    shift_data_reg <= next_shift;
    if (finish) begin
      rx_buf <= next_shift;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      ctrl <= `CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl <= wr_data;
    end
  end

  // transfer engine
  always @(posedge clock) begin
    if (sys_rst) begin
      busy      <= 1'b0;
      bit_cnt   <= 3'd0;
      lead_seen <= 1'b0;
      in_bit    <= 1'b0;
      data_out  <= 1'b0;
    end else begin
      if (sample_ev) begin
        in_bit <= din;
      end
      if (load || shift_ev || finish) begin
        data_out <= out_bit(next_shift, bit_order_sel);
      end
      if (abort || finish) begin
        busy      <= 1'b0;
        bit_cnt   <= 3'd0;
        lead_seen <= 1'b0;
      end else begin
        if ((load && master_on) || s_edge) begin
          busy <= 1'b1;
        end
        if (lead) begin
          lead_seen <= 1'b1;
        end
        if (shift_ev) begin
          bit_cnt <= bit_cnt + 3'd1;
        end
      end
    end
  end

  // clock generator; idle sck rests at the chosen level
  always @(posedge clock) begin
    if (sys_rst) begin
      sck_out  <= 1'b0;
      half_cnt <= 8'h00;
    end else if (!master_on || !busy || finish) begin
      sck_out  <= clock_idle_level;
      half_cnt <= 8'h00;
    end else if (gen_tick) begin
      sck_out  <= !sck_out;
      half_cnt <= 8'h00;
    end else begin
      half_cnt <= half_cnt + 8'h01;
    end
  end

  // one output flop serves both directions
  assign mosi_out = data_out;
  assign miso_out = data_out;

  // flags: a set in the clearing cycle wins
  always @(posedge clock) begin
    if (sys_rst) begin
      xfer_done_flag <= 1'b0;
    end else if (finish) begin
      xfer_done_flag <= 1'b1;
    end else if (clear_now) begin
      xfer_done_flag <= 1'b0;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      write_clash_flag <= 1'b0;
    end else if (clash) begin
      write_clash_flag <= 1'b1;
    end else if (clear_now) begin
      write_clash_flag <= 1'b0;
    end
  end

  // any data access disarms, so a stale status read cannot clear later flags
  always @(posedge clock) begin
    if (sys_rst) begin
      clear_armed <= 1'b0;
    end else if (status_rd && (xfer_done_flag || write_clash_flag)) begin
      clear_armed <= 1'b1;
    end else if (data_wr || data_rd) begin
      clear_armed <= 1'b0;
    end
  end

  // read data stands one cycle, zero otherwise
  always @(posedge clock) begin
    if (sys_rst || !rd_stb) begin
      rd_data <= 8'h00;
    end else begin
      case (addr)
        `SPI_ADDR_DATA:    rd_data <= rx_buf;
        `SPI_ADDR_STATUS:  rd_data <= {xfer_done_flag, write_clash_flag, 6'h00};
        `SPI_ADDR_CONTROL: rd_data <= ctrl;
        default:           rd_data <= 8'h00;
      endcase
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      irq_request <= 1'b0;
      wake_idle   <= 1'b0;
    end else begin
      irq_request <= serial_irq_gate && (spi_irq_src || uart_irq_req);
      wake_idle   <= finish && !controller_sel;
    end
  end

  always @(posedge clock) begin
    if (sys_rst) begin
      sck_oe  <= 1'b0;
      mosi_oe <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      sck_oe  <= master_on;
      mosi_oe <= master_on;
      miso_oe <= slave_on;
    end
  end

endmodule // spi_master_slave_port

/* File: rtl/spi_port_defs.vh */
`ifndef SPI_PORT_DEFS_VH
`define SPI_PORT_DEFS_VH

`define SPI_ADDR_DATA      8'h86
`define SPI_ADDR_STATUS    8'haa
`define SPI_ADDR_CONTROL   8'hd5

`define CTRL_IRQ_EN        7
`define CTRL_PORT_ON       6
`define CTRL_ORDER         5
`define CTRL_MASTER        4
`define CTRL_IDLE_LEVEL    3
`define CTRL_PHASE         2
`define CTRL_RATE_HI       1
`define CTRL_RATE_LO       0
`define STAT_DONE          7
`define STAT_CLASH         6

`define CTRL_RESET         8'h04
`define STAT_RESET         8'h00

`define DIV_CODE0          4
`define DIV_CODE1          16
`define DIV_CODE2          64
`define DIV_CODE3          128

`define CLK_MHZ            200
`define MAX_BIT_KHZ        1500
`define MIN_BIT_CYCLES     ((`CLK_MHZ * 1000 + `MAX_BIT_KHZ - 1) / `MAX_BIT_KHZ)

`endif
